// ==== sdpc_pkg.sv ====
// Shared constants, command and power types for the SDRAM write/precharge core
package sdpc_pkg;

    // ==========================================================
    // Geometry
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int DATA_W = 32;
    localparam int MASK_W = 4;
    localparam int ALL_BANKS_POS = 10;
    localparam int LAT_MAX = 3;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ROW_PRECHARGE_NS = 20;
    localparam int ROW_PRECHARGE_CYC =
        (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Burst length code for a full page
    localparam logic [2:0] BL_FULL_PAGE = 3'h7;

    // Command pin codes, ordered {ras_n, cas_n, we_n}
    localparam logic [2:0] PIN_LOAD_MODE = 3'h0;
    localparam logic [2:0] PIN_REFRESH = 3'h1;
    localparam logic [2:0] PIN_PRECHARGE = 3'h2;
    localparam logic [2:0] PIN_ACTIVE = 3'h3;
    localparam logic [2:0] PIN_WRITE = 3'h4;
    localparam logic [2:0] PIN_READ = 3'h5;
    localparam logic [2:0] PIN_TERMINATE = 3'h6;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
        CMD_PRECHARGE, CMD_TERMINATE, CMD_REFRESH, CMD_LOAD_MODE
    } sdpc_cmd_type;

    typedef enum logic [1:0] {
        PWR_RUN, PWR_SUSPEND, PWR_DOWN
    } sdpc_pwr_type;

    // Command inhibit and NOP both decode to CMD_NOP
    function automatic sdpc_cmd_type sdpc_decode(input logic cs_n,
                                                 input logic [2:0] pins);
        sdpc_cmd_type c;
        c = CMD_NOP;
        if (!cs_n) begin
            case (pins)
                PIN_LOAD_MODE: c = CMD_LOAD_MODE;
                PIN_REFRESH: c = CMD_REFRESH;
                PIN_PRECHARGE: c = CMD_PRECHARGE;
                PIN_ACTIVE: c = CMD_ACTIVE;
                PIN_WRITE: c = CMD_WRITE;
                PIN_READ: c = CMD_READ;
                PIN_TERMINATE: c = CMD_TERMINATE;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction : sdpc_decode

endpackage : sdpc_pkg

// ==== sdpc_bank_if.sv ====
// Bank open/close requests and bank status between core and tracker
`timescale 1ns/1ps
interface sdpc_bank_if #(parameter int BANKS = sdpc_pkg::BANKS);
    logic [BANKS-1:0] open_req;
    logic [BANKS-1:0] close_req;
    logic [BANKS-1:0] is_open;
    logic [BANKS-1:0] is_idle;

    modport ctrl (output open_req, output close_req,
                  input is_open, input is_idle);
    modport bank (input open_req, input close_req,
                  output is_open, output is_idle);
endinterface : sdpc_bank_if

// ==== sdpc_bank_track.sv ====
// Per-bank open row flag and row precharge timer
`timescale 1ns/1ps
module sdpc_bank_track #(
    parameter int BANKS = sdpc_pkg::BANKS,
    parameter int TRP_CYC = sdpc_pkg::ROW_PRECHARGE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Requests from the core
    sdpc_bank_if.bank bif
);

    localparam int CNT_W = $clog2(TRP_CYC + 1);
    localparam logic [CNT_W-1:0] TRP_LOAD = CNT_W'(TRP_CYC);

    // ==========================================================
    // Bank state, one copy per bank
    genvar i;
    generate
        for (i = 0; i < BANKS; i++) begin : g_bank
            logic open_ff;
            logic [CNT_W-1:0] trp_ff;

            // Close wins over open; a closed bank waits out the timer
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    open_ff <= 1'b0;
                    trp_ff <= '0;
                end else if (bif.close_req[i] && open_ff) begin
                    open_ff <= 1'b0;
                    trp_ff <= TRP_LOAD;
                end else if (bif.open_req[i]) begin
                    open_ff <= 1'b1;
                end else if (trp_ff != '0) begin
                    trp_ff <= trp_ff - 1'b1;
                end
            end

            assign bif.is_open[i] = open_ff;
            assign bif.is_idle[i] = !open_ff && (trp_ff == '0);
        end
    endgenerate

endmodule : sdpc_bank_track

// ==== sdpc_core.sv ====
// SDRAM write burst, precharge, power-down and clock suspend core
// ==============================================================
`timescale 1ns/1ps
module sdpc_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Command pins
    input wire logic clock_enable,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [sdpc_pkg::ADDR_W-1:0] addr,
    // Data pins
    input wire logic [sdpc_pkg::MASK_W-1:0] dqm,
    input wire logic [sdpc_pkg::DATA_W-1:0] dq_in,
    output logic [sdpc_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    // Mode settings
    input wire logic [2:0] burst_length,
    input wire logic [1:0] read_latency,
    input wire logic write_burst_mode_bit,
    // Array port
    input wire logic [sdpc_pkg::DATA_W-1:0] rd_word,
    output logic mem_we,
    output logic [sdpc_pkg::BANK_W-1:0] mem_bank,
    output logic [sdpc_pkg::COL_W-1:0] mem_col,
    output logic [sdpc_pkg::DATA_W-1:0] mem_data,
    output logic [sdpc_pkg::MASK_W-1:0] mem_byte_en,
    // Status
    output logic [sdpc_pkg::BANKS-1:0] bank_open,
    output logic power_down,
    output logic precharge_power_down,
    output logic clock_suspend
);

    localparam int COL_W = sdpc_pkg::COL_W;
    localparam int BANK_W = sdpc_pkg::BANK_W;
    localparam int BANKS = sdpc_pkg::BANKS;
    localparam int LAT_MAX = sdpc_pkg::LAT_MAX;

    // ==========================================================
    // Registers
    sdpc_pkg::sdpc_pwr_type pwr_ff, nxt_pwr;
    logic wr_active_ff, nxt_wr_active;
    logic wr_full_ff, nxt_wr_full;
    logic wr_ap_ff, nxt_wr_ap;
    logic [3:0] wr_left_ff, nxt_wr_left;
    logic [COL_W-1:0] wr_col_ff, nxt_wr_col;
    logic [BANK_W-1:0] wr_bank_ff, nxt_wr_bank;
    logic rd_active_ff, nxt_rd_active;
    logic rd_full_ff, nxt_rd_full;
    logic rd_ap_ff, nxt_rd_ap;
    logic [3:0] rd_left_ff, nxt_rd_left;
    logic [BANK_W-1:0] rd_bank_ff, nxt_rd_bank;
    logic [LAT_MAX-1:0] rd_pipe_ff, nxt_rd_pipe;
    logic dq_oe_ff, nxt_dq_oe;
    logic [sdpc_pkg::DATA_W-1:0] dq_out_ff;
    logic mem_we_ff;
    logic [BANK_W-1:0] mem_bank_ff;
    logic [COL_W-1:0] mem_col_ff;
    logic [sdpc_pkg::DATA_W-1:0] mem_data_ff;
    logic [sdpc_pkg::MASK_W-1:0] mem_byte_en_ff;
    logic pd_pre_ff;

    sdpc_bank_if #(.BANKS(BANKS)) bif ();

    // ==========================================================
    // Command decode
    sdpc_pkg::sdpc_cmd_type cmd;
    logic edge_live;
    logic [BANK_W-1:0] cmd_bank;
    logic [COL_W-1:0] cmd_col;
    logic all_banks_select_bit;
    logic cmd_nop, wr_cmd, rd_cmd, term_cmd, pre_cmd, act_cmd;
    logic [BANKS-1:0] bank_hot;
    logic [BANKS-1:0] pre_mask;

    assign cmd = sdpc_pkg::sdpc_decode(cs_n, {ras_n, cas_n, we_n});
    // Only a running internal clock takes commands
    assign edge_live = (pwr_ff == sdpc_pkg::PWR_RUN);
    assign cmd_bank = {bank_select_high, bank_select_low};
    assign cmd_col = addr[COL_W-1:0];
    assign all_banks_select_bit = addr[sdpc_pkg::ALL_BANKS_POS];
    assign cmd_nop = (cmd == sdpc_pkg::CMD_NOP);
    assign wr_cmd = edge_live && (cmd == sdpc_pkg::CMD_WRITE);
    assign rd_cmd = edge_live && (cmd == sdpc_pkg::CMD_READ);
    assign term_cmd = edge_live && (cmd == sdpc_pkg::CMD_TERMINATE);
    assign pre_cmd = edge_live && (cmd == sdpc_pkg::CMD_PRECHARGE);
    assign act_cmd = edge_live && (cmd == sdpc_pkg::CMD_ACTIVE);
    assign bank_hot = BANKS'(1) << cmd_bank;
    assign pre_mask = all_banks_select_bit ? '1 : bank_hot;

    // ==========================================================
    // Burst geometry
    logic len_full;
    logic [3:0] bl_len;
    logic [COL_W-1:0] len_mask;
    logic [3:0] wr_len;
    logic wr_len_full;

    assign len_full = (burst_length == sdpc_pkg::BL_FULL_PAGE);
    assign bl_len = 4'h1 << burst_length[1:0];
    // full page wraps over the whole row
    assign len_mask = len_full ? '1 : COL_W'(bl_len - 4'h1);
    assign wr_len = write_burst_mode_bit ? 4'h1 : bl_len;
    assign wr_len_full = len_full && !write_burst_mode_bit;

    // ==========================================================
    // Write burst stepping
    logic wr_kill, wr_step, wr_last_step, wr_ap_done;
    logic [COL_W-1:0] wr_col_inc;

    // READ, TERMINATE or a PRECHARGE covering the burst's bank end the burst
    assign wr_kill = wr_active_ff && (rd_cmd || term_cmd
                     || (pre_cmd && pre_mask[wr_bank_ff]));
    // a suspended edge leaves the burst frozen
    assign wr_step = edge_live && wr_active_ff && !wr_cmd && !wr_kill;
    assign wr_last_step = wr_step && !wr_full_ff
                          && (wr_left_ff == 4'h1);
    // Sequential wrap inside the burst-aligned block
    assign wr_col_inc = (wr_col_ff & ~len_mask)
                        | (COL_W'(wr_col_ff + 1'b1) & len_mask);
    // auto precharge after the last word
    assign wr_ap_done = (wr_cmd && addr[sdpc_pkg::ALL_BANKS_POS]
                         && !wr_len_full && wr_len == 4'h1)
                        || (wr_last_step && wr_ap_ff);

    always_comb begin
        nxt_wr_active = wr_active_ff;
        nxt_wr_full = wr_full_ff;
        nxt_wr_ap = wr_ap_ff;
        nxt_wr_left = wr_left_ff;
        nxt_wr_col = wr_col_ff;
        nxt_wr_bank = wr_bank_ff;
        if (wr_cmd) begin
            // new WRITE restarts with its own word
            nxt_wr_active = wr_len_full || (wr_len != 4'h1);
            nxt_wr_full = wr_len_full;
            nxt_wr_ap = all_banks_select_bit;
            nxt_wr_left = wr_len - 4'h1;
            nxt_wr_col = cmd_col;
            nxt_wr_bank = cmd_bank;
        end else if (wr_kill) begin
            nxt_wr_active = 1'b0;
        end else if (wr_step) begin
            nxt_wr_col = wr_col_inc;
            if (!wr_full_ff) begin
                nxt_wr_left = wr_left_ff - 4'h1;
            end
            // fixed burst ends, later data is dropped
            if (wr_last_step) begin
                nxt_wr_active = 1'b0;
            end
        end
    end

    // ==========================================================
    // Read burst tracking, needed for suspend and auto precharge
    logic rd_kill, rd_step, rd_issue, rd_last, rd_ap_done;
    logic rd_ap_cut;

    assign rd_kill = rd_active_ff && (wr_cmd || term_cmd
                     || (pre_cmd && pre_mask[rd_bank_ff]));
    assign rd_step = edge_live && rd_active_ff && !rd_cmd && !rd_kill;
    assign rd_issue = rd_cmd || rd_step;
    assign rd_last = rd_step && !rd_full_ff && (rd_left_ff == 4'h1);
    // access elsewhere starts this bank's precharge
    assign rd_ap_cut = rd_active_ff && rd_ap_ff
                       && (rd_cmd || wr_cmd) && (cmd_bank != rd_bank_ff);
    assign rd_ap_done = rd_ap_cut || (rd_last && rd_ap_ff)
                        || (rd_cmd && all_banks_select_bit
                            && !len_full && bl_len == 4'h1);

    always_comb begin
        nxt_rd_active = rd_active_ff;
        nxt_rd_full = rd_full_ff;
        nxt_rd_ap = rd_ap_ff;
        nxt_rd_left = rd_left_ff;
        nxt_rd_bank = rd_bank_ff;
        if (rd_cmd) begin
            nxt_rd_active = len_full || (bl_len != 4'h1);
            nxt_rd_full = len_full;
            nxt_rd_ap = all_banks_select_bit;
            nxt_rd_left = bl_len - 4'h1;
            nxt_rd_bank = cmd_bank;
        end else if (rd_kill || rd_last) begin
            nxt_rd_active = 1'b0;
        end else if (rd_step && !rd_full_ff) begin
            nxt_rd_left = rd_left_ff - 4'h1;
        end
    end

    // ==========================================================
    // Output data pipeline
    logic [1:0] lat_idx;

    assign lat_idx = (read_latency == 2'h0) ? 2'h0 : read_latency - 2'h1;

    always_comb begin
        nxt_rd_pipe = rd_pipe_ff;
        nxt_dq_oe = dq_oe_ff;
        if (pwr_ff == sdpc_pkg::PWR_DOWN) begin
            nxt_rd_pipe = '0;
            nxt_dq_oe = 1'b0;
        end else if (edge_live) begin
            nxt_rd_pipe = {rd_pipe_ff[LAT_MAX-2:0], rd_issue};
            // A registered WRITE puts the data pins in high impedance
            if (wr_cmd) begin
                nxt_rd_pipe = '0;
            end
            nxt_dq_oe = nxt_rd_pipe[lat_idx];
        end
    end

    // ==========================================================
    // Power-down and clock suspend
    logic access_busy;
    logic banks_idle;

    assign access_busy = wr_active_ff || rd_active_ff
                         || (rd_pipe_ff != '0) || wr_cmd || rd_cmd;
    assign banks_idle = &bif.is_idle;

    always_comb begin
        nxt_pwr = pwr_ff;
        unique case (pwr_ff)
            sdpc_pkg::PWR_RUN: begin
                // low enable during a burst freezes next edge
                if (!clock_enable && access_busy) begin
                    nxt_pwr = sdpc_pkg::PWR_SUSPEND;
                end else if (!clock_enable && cmd_nop) begin
                    nxt_pwr = sdpc_pkg::PWR_DOWN;
                end
            end
            sdpc_pkg::PWR_SUSPEND: begin
                // resume on the edge after enable is high
                if (clock_enable) begin
                    nxt_pwr = sdpc_pkg::PWR_RUN;
                end
            end
            sdpc_pkg::PWR_DOWN: begin
                // leave only on enable high with NOP
                if (clock_enable && cmd_nop) begin
                    nxt_pwr = sdpc_pkg::PWR_RUN;
                end
            end
        endcase
    end

    // ==========================================================
    // Bank requests
    logic [BANK_W-1:0] ap_wr_bank_sel;

    // A one-word auto-precharge write closes the bank it names
    assign ap_wr_bank_sel = wr_cmd ? cmd_bank : wr_bank_ff;
    assign bif.open_req = act_cmd ? bank_hot : '0;
    assign bif.close_req = (pre_cmd ? pre_mask : '0)
        | (wr_ap_done ? BANKS'(1) << ap_wr_bank_sel : '0)
        | (rd_ap_done ? BANKS'(1)
           << (rd_ap_cut || !rd_cmd ? rd_bank_ff : cmd_bank) : '0);

    sdpc_bank_track #(
        .BANKS(BANKS),
        .TRP_CYC(sdpc_pkg::ROW_PRECHARGE_CYC)
    ) u_bank_track (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .bif(bif)
    );

    // ==========================================================
    // Array write port
    logic word_take;
    logic [COL_W-1:0] word_col;

    // first word with the command, then one per live edge
    assign word_take = wr_cmd || wr_step;
    assign word_col = wr_cmd ? cmd_col : wr_col_inc;

    // mask gates the word on its own edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_we_ff <= 1'b0;
            mem_byte_en_ff <= '0;
        end else begin
            mem_we_ff <= word_take && (dqm != '1);
            mem_byte_en_ff <= word_take ? ~dqm : '0;
        end
    end

    // Address and data follow each taken word
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_bank_ff <= '0;
            mem_col_ff <= '0;
            mem_data_ff <= '0;
        end else if (word_take) begin
            mem_bank_ff <= wr_cmd ? cmd_bank : wr_bank_ff;
            mem_col_ff <= word_col;
            mem_data_ff <= dq_in;
        end
    end

    // ==========================================================
    // Burst and power state
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_ff <= sdpc_pkg::PWR_RUN;
            wr_active_ff <= 1'b0;
            wr_full_ff <= 1'b0;
            wr_ap_ff <= 1'b0;
            wr_left_ff <= '0;
            wr_col_ff <= '0;
            wr_bank_ff <= '0;
        end else begin
            pwr_ff <= nxt_pwr;
            wr_active_ff <= nxt_wr_active;
            wr_full_ff <= nxt_wr_full;
            wr_ap_ff <= nxt_wr_ap;
            wr_left_ff <= nxt_wr_left;
            wr_col_ff <= nxt_wr_col;
            wr_bank_ff <= nxt_wr_bank;
        end
    end

    // Read tracking and data pins
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_active_ff <= 1'b0;
            rd_full_ff <= 1'b0;
            rd_ap_ff <= 1'b0;
            rd_left_ff <= '0;
            rd_bank_ff <= '0;
            rd_pipe_ff <= '0;
            dq_oe_ff <= 1'b0;
        end else begin
            rd_active_ff <= nxt_rd_active;
            rd_full_ff <= nxt_rd_full;
            rd_ap_ff <= nxt_rd_ap;
            rd_left_ff <= nxt_rd_left;
            rd_bank_ff <= nxt_rd_bank;
            rd_pipe_ff <= nxt_rd_pipe;
            dq_oe_ff <= nxt_dq_oe;
        end
    end

    // driven word holds while the clock is suspended
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_out_ff <= '0;
        end else if (edge_live && nxt_dq_oe) begin
            dq_out_ff <= rd_word;
        end
    end

    // Precharge flavour of power-down is fixed at entry
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pd_pre_ff <= 1'b0;
        end else begin
            pd_pre_ff <= (nxt_pwr == sdpc_pkg::PWR_DOWN)
                         && (pwr_ff == sdpc_pkg::PWR_DOWN
                             ? pd_pre_ff : banks_idle);
        end
    end

    // ==========================================================
    // Outputs
    assign dq_out = dq_out_ff;
    assign dq_oe = dq_oe_ff;
    assign mem_we = mem_we_ff;
    assign mem_bank = mem_bank_ff;
    assign mem_col = mem_col_ff;
    assign mem_data = mem_data_ff;
    assign mem_byte_en = mem_byte_en_ff;
    assign bank_open = bif.is_open;
    assign power_down = (pwr_ff == sdpc_pkg::PWR_DOWN);
    assign precharge_power_down = pd_pre_ff;
    assign clock_suspend = (pwr_ff == sdpc_pkg::PWR_SUSPEND);

endmodule : sdpc_core

// ==== sdpc_chk.sv ====
// Port checker for the SDRAM write/precharge core
`timescale 1ns/1ps
module sdpc_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Command and data pins
    input wire logic clock_enable,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [11:0] addr,
    input wire logic [3:0] dqm,
    // Core outputs
    input wire logic dq_oe,
    input wire logic mem_we,
    input wire logic [7:0] mem_col,
    input wire logic [3:0] mem_byte_en,
    input wire logic [3:0] bank_open,
    input wire logic power_down,
    input wire logic clock_suspend
);
    // ==========================================================
    // Command decode on a live edge
    wire [2:0] pins = {ras_n, cas_n, we_n};
    wire run = clock_enable && !power_down && !clock_suspend && !cs_n;
    wire [7:0] col = addr[7:0];
    wire wr = run && pins == sdpc_pkg::PIN_WRITE && dqm != 4'hF;
    wire stop = run && (pins == sdpc_pkg::PIN_READ ||
                        pins == sdpc_pkg::PIN_TERMINATE);
    wire pre_all = run && pins == sdpc_pkg::PIN_PRECHARGE && addr[10];
    wire nop = cs_n || pins == 3'h7;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    wr_word_a: assert property (wr |=> mem_we && mem_col == $past(col))
        else $error("write word not stored");
    mask_bytes_a: assert property (mem_we |-> mem_byte_en == ~$past(dqm))
        else $error("byte enables differ from mask");
    trunc_stop_a: assert property (stop |=> !mem_we)
        else $error("word stored on truncating edge");
    pre_all_a: assert property (pre_all |=> bank_open == 4'h0)
        else $error("bank left open after precharge all");
    pd_entry_a: assert property ($rose(power_down) |->
        !$past(clock_enable) && $past(nop)) else $error("bad power-down entry");
    pd_quiet_a: assert property (power_down |-> !mem_we && !dq_oe)
        else $error("activity in power-down");
    pd_exit_a: assert property (power_down && clock_enable && nop
        |=> !power_down) else $error("power-down not left");
    susp_hold_a: assert property (clock_suspend |=> !mem_we && $stable(dq_oe))
        else $error("suspended edge acted");
    susp_exit_a: assert property (clock_suspend && clock_enable
        |=> !clock_suspend) else $error("suspend not left");

    // Main scenarios reached
    cover property (wr ##1 wr);
    cover property ($rose(power_down));
    cover property ($rose(clock_suspend));
endmodule : sdpc_chk

bind sdpc_core sdpc_chk u_chk (.sys_clk, .reset_n, .clock_enable, .cs_n,
    .ras_n, .cas_n, .we_n, .addr, .dqm, .dq_oe, .mem_we, .mem_col,
    .mem_byte_en, .bank_open, .power_down, .clock_suspend);

// ==== sdpc_ctl_model.sv ====
// Memory controller model driving the core's command and data pins
`timescale 1ns/1ps
module sdpc_ctl_model (
    // Clock
    input wire logic sys_clk,
    // Pins toward the core
    output logic clock_enable,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic bank_select_low,
    output logic bank_select_high,
    output logic [11:0] addr,
    output logic [3:0] dqm,
    output logic [31:0] dq_in
);
    // ==========================================================
    // Idle pins: inhibit with clock enable high
    initial begin
        {clock_enable, cs_n, ras_n, cas_n, we_n} = 5'h1F;
        {bank_select_high, bank_select_low} = 2'h0;
        addr = 12'h000;
        dqm = 4'h0;
        dq_in = 32'h0;
    end

    // One command per edge; driven 1 ns after it to meet setup
    // Clock enable setup
    task automatic issue(input logic [2:0] p, input logic [1:0] b,
                         input logic [11:0] a, input logic [3:0] m,
                         input logic [31:0] d, input logic k);
        @(posedge sys_clk);
        #1;
        cs_n = &p;
        {ras_n, cas_n, we_n} = p;
        {bank_select_high, bank_select_low} = b;
        addr = a;
        dqm = m;
        dq_in = d;
        clock_enable = k;
    endtask : issue
endmodule : sdpc_ctl_model

// ==== tb.sv ====
// Self-checking bench for the SDRAM write/precharge core
`timescale 1ns/1ps
module tb;
    // ==========================================================
    // Pins and bookkeeping
    logic sys_clk, reset_n, clock_enable, cs_n, ras_n, cas_n, we_n;
    logic bank_select_low, bank_select_high, dq_oe, mem_we, power_down;
    logic precharge_power_down, clock_suspend, write_burst_mode_bit;
    logic [2:0] burst_length;
    logic [1:0] read_latency, mem_bank;
    logic [11:0] addr;
    logic [3:0] dqm, mem_byte_en, bank_open;
    logic [31:0] dq_in, dq_out, rd_word, mem_data, rd_exp;
    logic [7:0] mem_col;
    logic [31:0] seed = 32'h951A;
    logic [45:0] got;
    logic [45:0] exp_q[$];
    int fail_count = 0;
    int checks_done = 0;

    sdpc_ctl_model ctl (.sys_clk, .clock_enable, .cs_n, .ras_n, .cas_n,
        .we_n, .bank_select_low, .bank_select_high, .addr, .dqm, .dq_in);
    sdpc_core DUT (.sys_clk, .reset_n, .clock_enable, .cs_n, .ras_n,
        .cas_n, .we_n, .bank_select_low, .bank_select_high, .addr, .dqm,
        .dq_in, .dq_out, .dq_oe, .burst_length, .read_latency,
        .write_burst_mode_bit, .rd_word, .mem_we, .mem_bank, .mem_col,
        .mem_data, .mem_byte_en, .bank_open, .power_down,
        .precharge_power_down, .clock_suspend);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h00400007 : 32'h0);
    endfunction : lfsr

    task automatic chk(input logic [45:0] g, input logic [45:0] w);
        checks_done++;
        if (g !== w) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h want %h", $time, g, w);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    // Random data on every cycle, so stray writes never look right
    task automatic op(input logic [2:0] p, input logic [1:0] b,
                      input logic [11:0] a, input logic [3:0] m,
                      input logic k, input logic keep, input logic [7:0] c);
        seed = lfsr(seed);
        if (keep) exp_q.push_back({b, c, seed, ~m});
        ctl.issue(p, b, a, m, seed, k);
    endtask : op

    // Write of n beats from column c, first k beats expected stored
    task automatic burst(input logic [1:0] b, input logic [7:0] c,
                         input int n, input int k, input logic [3:0] m);
        for (int i = 0; i < n; i++)
            op(i == 0 ? sdpc_pkg::PIN_WRITE : 3'h7, b, {4'h0, c}, m, 1'b1,
               i < k, c + 8'(i));
    endtask : burst

    task automatic fin(input int t);
        for (int i = 0; i < 3; i++) op(3'h7, 2'h0, 12'h0, 4'h0, 1'b1, 1'b0, 8'h0);
        $display("test %0d done", t);
    endtask : fin

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) rd_word <= #1 ~seed;

    // Every stored word must be the oldest expected one
    always @(negedge sys_clk) begin
        if (mem_we === 1'b1) begin
            got = {mem_bank, mem_col, mem_data, mem_byte_en};
            chk(got, exp_q.size() != 0 ? exp_q.pop_front() : ~got);
        end
    end

    // Run needs about 90 cycles; wide margin
    initial begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        close_out();
    end

    initial begin
        {reset_n, write_burst_mode_bit, read_latency} = 4'h2;
        burst_length = 3'h1;
        repeat (8) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        for (int b = 0; b < 4; b++) ctl.issue(3'h3, 2'(b), 12'h0, 4'h0, 32'h0, 1'b1);
        fin(0);
        chk(46'(bank_open), 46'hF);
        burst(0, 8'h04, 4, 2, 4'h3);
        fin(1);
        burst_length = 3'h3;
        burst(1, 8'h10, 3, 3, 4'h0);
        burst(1, 8'h20, 2, 2, 4'h0);
        op(sdpc_pkg::PIN_READ, 1, 12'h20, 4'h0, 1, 0, 0);
        burst(2, 8'h30, 3, 3, 4'h0);
        op(sdpc_pkg::PIN_TERMINATE, 2, 12'h0, 4'h0, 1, 0, 0);
        fin(2);
        burst_length = 3'h7;
        burst(3, 8'hFE, 4, 4, 4'h8);
        op(sdpc_pkg::PIN_TERMINATE, 3, 12'h0, 4'h0, 1, 0, 0);
        burst_length = 3'h2;
        write_burst_mode_bit = 1'b1;
        burst(0, 8'h40, 3, 1, 4'h0);
        fin(3);
        write_burst_mode_bit = 1'b0;
        // Clock enable low on beat 1 freezes beat 2
        for (int i = 0; i < 5; i++) begin
            op(i == 0 ? 3'h4 : 3'h7, 0, 12'h50, 4'h0, i != 1, i != 2,
               8'h50 + 8'(i - (i > 2)));
            if (i == 2) chk(46'(clock_suspend), 46'h1);
        end
        fin(4);
        burst_length = 3'h0;
        op(3'h4, 2, 12'h460, 4'h0, 1, 1, 8'h60);
        fin(5);
        chk(46'(bank_open), 46'hB);
        // Masked beats before and at precharge
        burst_length = 3'h2;
        burst(1, 8'h70, 1, 1, 4'h0);
        op(3'h7, 1, 12'h0, 4'hF, 1, 0, 0);
        op(sdpc_pkg::PIN_PRECHARGE, 1, 12'h0, 4'hF, 1, 0, 0);
        fin(6);
        chk(46'(bank_open), 46'h9);
        op(sdpc_pkg::PIN_PRECHARGE, 0, 12'h400, 4'h0, 1, 0, 0);
        fin(7);
        chk(46'(bank_open), 46'h0);
        op(3'h7, 0, 12'h0, 4'h0, 0, 0, 0);
        op(3'h4, 0, 12'h80, 4'h0, 0, 0, 0);
        chk(46'({power_down, precharge_power_down}), 46'h3);
        op(3'h7, 0, 12'h0, 4'h0, 1, 0, 0);
        op(3'h7, 0, 12'h0, 4'h0, 1, 0, 0);
        chk(46'(power_down), 46'h0);
        fin(8);
        write_burst_mode_bit = 1'b1;
        for (int i = 0; i < 2; i++) begin
            for (int b = 0; b < 2 - i; b++)
                ctl.issue(3'h3, 2'(b), 12'h0, 4'(15 * i), 32'h0, 1'b1);
            op(3'h5, 0, 12'h400, 4'(15 * i), 1, 0, 0);
            op(3'h4 + 3'(i == 0), 1, 12'h0, 4'h0, 1, i == 1, 8'h0);
            rd_exp = ~seed;
            op(3'h7, 0, 12'h0, 4'h0, 1, 0, 0);
            chk(46'({bank_open, dq_oe, i ? 32'h0 : dq_out}),
                46'({4'h2, i == 0, i ? 32'h0 : rd_exp}));
            fin(9 + i);
        end
        chk(46'(exp_q.size()), 46'h0);
        close_out();
    end
endmodule : tb
